// [irq_hold_and_key_irq_test.sv]
// self-checking bench for the interrupt hold and key interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "irqh_defines.svh"
module irq_hold_and_key_irq_test;
  import irqh_pkg::*;
  localparam logic [4:0] NORM = 5'h00;
  localparam logic [4:0] HOLD = 5'h10;
  localparam logic [4:0] TRAP = 5'h08;
  localparam logic [4:0] EI = 5'h14;
  localparam logic [4:0] RET = 5'h11;
  logic clk = 1'b0;
  logic srst = 1'b1;
  irqh_addr_t memAddr = 16'h0000;
  logic memWr = 1'b0;
  logic memRd = 1'b0;
  logic memBitOp = 1'b0;
  irqh_idx_t memBitPos = 3'h0;
  irqh_byte_t memWdata = 8'h00;
  logic [6:0] srcReq = 7'h00;
  irqh_byte_t memRdata, keyLines, keyPins;
  irqh_idx_t ackSource;
  logic instrDone, instrHold, instrTrap, instrEi, instrDi, instrRet, popIe, popIsp;
  logic ackValid, maskableIrqEnable, inServiceLevel;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  // ---------
  // harness
  // ---------
  irqh_ctrl u_dut (.clk(clk), .srst(srst), .memAddr(memAddr), .memWr(memWr), .memRd(memRd),
    .memBitOp(memBitOp), .memBitPos(memBitPos), .memWdata(memWdata), .memRdata(memRdata),
    .srcReq(srcReq), .keyLines(keyLines), .instrDone(instrDone), .instrHold(instrHold),
    .instrTrap(instrTrap), .instrEi(instrEi), .instrDi(instrDi), .instrRet(instrRet),
    .popIe(popIe), .popIsp(popIsp), .ackValid(ackValid), .ackSource(ackSource),
    .maskableIrqEnable(maskableIrqEnable), .inServiceLevel(inServiceLevel), .keyPins(keyPins));
  irqh_core_model u_core (.clk(clk), .instrDone(instrDone), .instrHold(instrHold),
    .instrTrap(instrTrap), .instrEi(instrEi), .instrDi(instrDi), .instrRet(instrRet),
    .popIe(popIe), .popIsp(popIsp), .keyLines(keyLines));
  always #10 clk = ~clk;
  // the whole run needs well under a thousand cycles; a hang stops here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input irqh_addr_t a, input irqh_byte_t d, input logic b, input irqh_idx_t p);
    @(posedge clk);
    memWr <= 1'b1;
    memAddr <= a;
    memWdata <= d;
    memBitOp <= b;
    memBitPos <= p;
    @(posedge clk);
    memWr <= 1'b0;
  endtask
  task automatic rd(input irqh_addr_t a, input irqh_byte_t exp);
    @(posedge clk);
    memRd <= 1'b1;
    memAddr <= a;
    @(posedge clk);
    memRd <= 1'b0;
    #1;
    chk(memRdata, exp);
  endtask
  task automatic pulse(input logic [6:0] r);
    @(posedge clk);
    srcReq <= r;
    @(posedge clk);
    srcReq <= 7'h00;
  endtask
  // ack is a one-cycle pulse, so it is looked at right after the completing edge
  task automatic step(input logic [4:0] kind, input logic a, input irqh_idx_t s);
    u_core.exec(kind);
    #1;
    chk({7'h00, ackValid}, {7'h00, a});
    if (a) chk({5'h00, ackSource}, {5'h00, s});
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_regs;
    rd(`IRQH_KEY_EN_ADDR, 8'h00);
    rd(`IRQH_MASK_ADDR, 8'hFF);
    chk({6'h00, maskableIrqEnable, inServiceLevel}, 8'h01);
    wr(`IRQH_KEY_EN_ADDR, 8'h5A, 1'b0, 3'h0);
    wr(`IRQH_KEY_EN_ADDR, 8'h01, 1'b1, 3'h0);
    wr(`IRQH_KEY_EN_ADDR, 8'h00, 1'b1, 3'h6);
    rd(`IRQH_KEY_EN_ADDR, 8'h1B);
    rd(16'h0000, 8'h00);
    wr(`IRQH_KEY_EN_ADDR, 8'h00, 1'b0, 3'h0);
    $display("test regs done");
  endtask
  task automatic t_ack;
    wr(`IRQH_MASK_ADDR, 8'hFB, 1'b0, 3'h0);
    step(EI, 1'b0, 3'h0);
    pulse(7'h08);
    step(NORM, 1'b0, 3'h0);
    rd(`IRQH_REQ_ADDR, 8'h08);
    wr(`IRQH_REQ_ADDR, 8'h00, 1'b0, 3'h0);
    pulse(7'h04);
    step(NORM, 1'b1, 3'h2);
    chk({7'h00, maskableIrqEnable}, 8'h00);
    pulse(7'h04);
    step(NORM, 1'b0, 3'h0);
    step(EI, 1'b0, 3'h0);
    step(NORM, 1'b1, 3'h2);
    $display("test ack done");
  endtask
  // plain hold and enable both defer by exactly one instruction
  task automatic t_hold;
    for (int i = 0; i < 2; i++) begin
      step(EI, 1'b0, 3'h0);
      pulse(7'h04);
      step(i ? EI : HOLD, 1'b0, 3'h0);
      step(NORM, 1'b1, 3'h2);
    end
    step(EI, 1'b0, 3'h0);
    pulse(7'h04);
    step(TRAP, 1'b0, 3'h0);
    chk({7'h00, maskableIrqEnable}, 8'h00);
    step(EI, 1'b0, 3'h0);
    step(NORM, 1'b1, 3'h2);
    $display("test hold done");
  endtask
  task automatic t_prio;
    wr(`IRQH_MASK_ADDR, 8'hF3, 1'b0, 3'h0);
    wr(`IRQH_LEVEL_ADDR, 8'hF7, 1'b0, 3'h0);
    step(EI, 1'b0, 3'h0);
    pulse(7'h0C);
    step(NORM, 1'b1, 3'h3);
    chk({7'h00, inServiceLevel}, 8'h00);
    step(EI, 1'b0, 3'h0);
    step(NORM, 1'b0, 3'h0);
    step(RET, 1'b0, 3'h0);
    step(NORM, 1'b1, 3'h2);
    wr(`IRQH_LEVEL_ADDR, 8'hFF, 1'b0, 3'h0);
    step(EI, 1'b0, 3'h0);
    pulse(7'h0C);
    step(NORM, 1'b1, 3'h2);
    step(EI, 1'b0, 3'h0);
    step(NORM, 1'b1, 3'h3);
    $display("test prio done");
  endtask
  task automatic t_key;
    wr(`IRQH_MASK_ADDR, 8'h7F, 1'b0, 3'h0);
    wr(`IRQH_KEY_EN_ADDR, 8'h08, 1'b0, 3'h0);
    step(EI, 1'b0, 3'h0);
    u_core.keys(8'hDF);
    repeat (5) @(posedge clk);
    #1;
    chk(keyPins, 8'hDF);
    step(NORM, 1'b0, 3'h0);
    u_core.keys(8'hD7);
    repeat (5) @(posedge clk);
    step(NORM, 1'b1, 3'h7);
    // enabling a line that is already low must not fire on its own
    wr(`IRQH_KEY_EN_ADDR, 8'h28, 1'b0, 3'h0);
    rd(`IRQH_REQ_ADDR, 8'h00);
    u_core.keys(8'hFF);
    $display("test key done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_ack();
    t_hold();
    t_prio();
    t_key();
    report_and_stop();
  end
endmodule
`default_nettype wire

// [irqh_core_model.sv]
// core and key switch model facing the interrupt hold block
`timescale 1ns/1ps
`default_nettype none
module irqh_core_model (
  input wire logic clk,
  output logic instrDone,
  output logic instrHold,
  output logic instrTrap,
  output logic instrEi,
  output logic instrDi,
  output logic instrRet,
  output logic popIe,
  output logic popIsp,
  output logic [7:0] keyLines
);
  // ----
  // idle
  // ----
  // key lines sit on pull-ups, so an idle line reads high
  initial begin
    {instrDone, instrHold, instrTrap, instrEi, instrDi, instrRet} = 6'h00;
    {popIe, popIsp} = 2'h3;
    keyLines = 8'hFF;
  end
  // one instruction, kind = {hold, trap, ei, di, ret}; returns come flagged hold
  task automatic exec(input logic [4:0] kind);
    @(posedge clk);
    instrDone <= 1'b1;
    {instrHold, instrTrap, instrEi, instrDi, instrRet} <= kind;
    @(posedge clk);
    instrDone <= 1'b0;
    {instrHold, instrTrap, instrEi, instrDi, instrRet} <= 5'h00;
  endtask
  // contacts change just after an edge, never in it
  task automatic keys(input logic [7:0] lvl);
    @(posedge clk);
    keyLines <= lvl;
  endtask
endmodule
`default_nettype wire

// [irqh_ctrl.sv]
// interrupt acknowledge gating with hold instructions and key interrupt source
//
// What this block does
// - request needs flag 1 and mask 0; vectored only while global enable is 1
// - nesting only for equal or higher priority; lower ones stay pending
// - higher programmed level wins; ties go to lowest source number
// - with enable left 0 during service, new requests just stay pending
// - request during hold instruction waits until the next instruction completes
// - hold class: status word, returns, enable/disable, flag register accesses
// - soft trap is not hold class but clears the global enable
// - request flag setting ignores programmed level; level orders acknowledges and limits nesting during high-level service
// - falling edge on any enabled key line raises the key request
// - key enable bit n governs key line n; 0 ignores, 1 detects
// - key enable register writable per bit or byte; reset clears it
// - changing key enable never sets key request by itself; a line already low sees no edge
// - disabled key lines stay plain port pins
`timescale 1ns/1ps
`default_nettype none
`include "irqh_defines.svh"
module irqh_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire irqh_pkg::irqh_addr_t memAddr,
  input wire logic memWr,
  input wire logic memRd,
  input wire logic memBitOp,
  input wire irqh_pkg::irqh_idx_t memBitPos,
  input wire irqh_pkg::irqh_byte_t memWdata,
  output irqh_pkg::irqh_byte_t memRdata,
  input wire logic [6:0] srcReq,
  input wire irqh_pkg::irqh_byte_t keyLines,
  input wire logic instrDone,
  input wire logic instrHold,
  input wire logic instrTrap,
  input wire logic instrEi,
  input wire logic instrDi,
  input wire logic instrRet,
  input wire logic popIe,
  input wire logic popIsp,
  output logic ackValid,
  output irqh_pkg::irqh_idx_t ackSource,
  output logic maskableIrqEnable,
  output logic inServiceLevel,
  output irqh_pkg::irqh_byte_t keyPins
);
  import irqh_pkg::*;

  irqh_byte_t keyInputEnable_ff;
  irqh_byte_t requestFlag_ff;
  irqh_byte_t requestMask_ff;
  irqh_byte_t levelChoice_ff;
  irqh_byte_t keyMeta_ff;
  irqh_byte_t keySync_ff;
  irqh_byte_t keyPrev_ff;
  irqh_byte_t rdData_ff;
  logic ie_ff;
  logic isp_ff;
  logic ack_ff;
  irqh_idx_t ackSrc_ff;
  irqh_byte_t keyFall;
  irqh_byte_t hwSet;
  irqh_byte_t ackClr;
  irqh_byte_t ready;
  logic takeAck;
  logic anyPick;
  irqh_idx_t pickIdx;

  // ---------------------------------------------------------------
  // register write helper
  // ---------------------------------------------------------------
  // a bit operation touches one bit and keeps the rest
  function automatic irqh_byte_t wrByte(input irqh_byte_t old, input logic bitOp,
                                        input irqh_idx_t pos, input irqh_byte_t wd);
    irqh_byte_t res;
    res = old;
    if (bitOp) begin
      res[pos] = wd[0];
    end else begin
      res = wd;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // key line synchroniser and edge detect
  // ---------------------------------------------------------------
  // first stage feeds only the second; edge logic looks at later stages
  always_ff @(posedge clk) begin
    if (srst) begin
      keyMeta_ff <= 8'hFF;
      keySync_ff <= 8'hFF;
      keyPrev_ff <= 8'hFF;
    end else begin
      keyMeta_ff <= keyLines;
      keySync_ff <= keyMeta_ff;
      keyPrev_ff <= keySync_ff;
    end
  end

  // one detector per line, gated by its own enable bit
  genvar gi;
  generate
    for (gi = 0; gi < `IRQH_NSRC; gi++) begin : g_key
      assign keyFall[gi] = keyInputEnable_ff[gi] & keyPrev_ff[gi] & ~keySync_ff[gi];
    end
  endgenerate

  // port pins always see the synchronised level, detection or not
  always_ff @(posedge clk) begin
    if (srst) begin
      keyPins <= 8'hFF;
    end else begin
      keyPins <= keySync_ff;
    end
  end

  // ---------------------------------------------------------------
  // key enable register
  // ---------------------------------------------------------------
  // no guard on change: a line already low when enabled shows no falling edge
  always_ff @(posedge clk) begin
    if (srst) begin
      keyInputEnable_ff <= `IRQH_KEY_EN_RST;
    end else if (memWr && memAddr == `IRQH_KEY_EN_ADDR) begin
      keyInputEnable_ff <= wrByte(keyInputEnable_ff, memBitOp, memBitPos, memWdata);
    end
  end

  // ---------------------------------------------------------------
  // request flags
  // ---------------------------------------------------------------
  // hardware sets never look at the level register
  assign hwSet = {|keyFall, srcReq};
  assign ackClr = takeAck ? 8'(8'h01 << pickIdx) : 8'h00;

  // a set arriving with a software or acknowledge clear wins
  always_ff @(posedge clk) begin
    if (srst) begin
      requestFlag_ff <= `IRQH_REQ_RST;
    end else if (memWr && memAddr == `IRQH_REQ_ADDR) begin
      requestFlag_ff <= (wrByte(requestFlag_ff, memBitOp, memBitPos, memWdata) & ~ackClr)
                        | hwSet;
    end else begin
      requestFlag_ff <= (requestFlag_ff & ~ackClr) | hwSet;
    end
  end

  // mask and level registers
  always_ff @(posedge clk) begin
    if (srst) begin
      requestMask_ff <= `IRQH_MASK_RST;
      levelChoice_ff <= `IRQH_LEVEL_RST;
    end else if (memWr && memAddr == `IRQH_MASK_ADDR) begin
      requestMask_ff <= wrByte(requestMask_ff, memBitOp, memBitPos, memWdata);
    end else if (memWr && memAddr == `IRQH_LEVEL_ADDR) begin
      levelChoice_ff <= wrByte(levelChoice_ff, memBitOp, memBitPos, memWdata);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // data one cycle after the read strobe; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_ff <= 8'h00;
    end else if (memRd) begin
      if (memAddr == `IRQH_KEY_EN_ADDR) begin
        rdData_ff <= keyInputEnable_ff;
      end else if (memAddr == `IRQH_REQ_ADDR) begin
        rdData_ff <= requestFlag_ff;
      end else if (memAddr == `IRQH_MASK_ADDR) begin
        rdData_ff <= requestMask_ff;
      end else if (memAddr == `IRQH_LEVEL_ADDR) begin
        rdData_ff <= levelChoice_ff;
      end else begin
        rdData_ff <= 8'h00;
      end
    end
  end
  assign memRdata = rdData_ff;

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  // while a high-level service runs only high-level requests may nest
  assign ready = requestFlag_ff & ~requestMask_ff
                 & (isp_ff ? 8'hFF : ~levelChoice_ff);

  // scan from the top so the lowest index of the best level is kept
  always_comb begin
    anyPick = 1'b0;
    pickIdx = 3'h0;
    for (int i = `IRQH_NSRC - 1; i >= 0; i--) begin
      if (ready[i] && !levelChoice_ff[i]) begin
        anyPick = 1'b1;
        pickIdx = 3'(i);
      end
    end
    if (!anyPick) begin
      for (int i = `IRQH_NSRC - 1; i >= 0; i--) begin
        if (ready[i]) begin
          anyPick = 1'b1;
          pickIdx = 3'(i);
        end
      end
    end
  end

  // hold-class completions never take a request; a return is refused even if not flagged hold
  assign takeAck = instrDone && !instrHold && !instrTrap && !instrRet
                   && ie_ff && anyPick;

  // ---------------------------------------------------------------
  // global enable and in-service level
  // ---------------------------------------------------------------
  // acknowledge and trap both clear the enable; only the enable op nests
  always_ff @(posedge clk) begin
    if (srst) begin
      ie_ff <= `IRQH_IE_RST;
      isp_ff <= `IRQH_ISP_RST;
    end else if (takeAck) begin
      ie_ff <= 1'b0;
      isp_ff <= levelChoice_ff[pickIdx];
    end else if (instrDone && instrTrap) begin
      ie_ff <= 1'b0;
    end else if (instrDone && instrRet) begin
      ie_ff <= popIe;
      isp_ff <= popIsp;
    end else if (instrDone && instrEi) begin
      ie_ff <= 1'b1;
    end else if (instrDone && instrDi) begin
      ie_ff <= 1'b0;
    end
  end
  assign maskableIrqEnable = ie_ff;
  assign inServiceLevel = isp_ff;

  // acknowledge pulse toward the core with the chosen vector
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      ackSrc_ff <= 3'h0;
    end else begin
      ack_ff <= takeAck;
      if (takeAck) begin
        ackSrc_ff <= pickIdx;
      end
    end
  end
  assign ackValid = ack_ff;
  assign ackSource = ackSrc_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence holdThenDone_s;
    instrDone && instrHold;
  endsequence

  sequence ackNow_s;
    takeAck;
  endsequence

  no_hold_ack_a: assert property (@(posedge clk) disable iff (srst)
    holdThenDone_s |=> !ackValid) else $error("acknowledge right after hold instruction");

  ack_needs_ie_a: assert property (@(posedge clk) disable iff (srst)
    ackNow_s |-> ie_ff && !requestMask_ff[pickIdx] && requestFlag_ff[pickIdx])
    else $error("acknowledge without enable, flag or clear mask");

  ack_clears_ie_a: assert property (@(posedge clk) disable iff (srst)
    ackNow_s |=> ackValid && !maskableIrqEnable) else $error("enable not cleared on ack");

  nest_level_a: assert property (@(posedge clk) disable iff (srst)
    (ackNow_s and !isp_ff) |-> !levelChoice_ff[pickIdx]) else $error("low level nested");

  ie_off_pend_a: assert property (@(posedge clk) disable iff (srst)
    !ie_ff && !(instrDone && (instrEi || instrRet)) |=> !ackValid)
    else $error("acknowledge while enable is off");

  trap_clears_a: assert property (@(posedge clk) disable iff (srst)
    instrDone && instrTrap |=> !maskableIrqEnable ##1 !ackValid)
    else $error("trap left enable set");

  key_fall_a: assert property (@(posedge clk) disable iff (srst)
    |(keyInputEnable_ff & $past(keySync_ff) & ~keySync_ff) |=> requestFlag_ff[`IRQH_KEY_SRC])
    else $error("key fall did not raise request");

  key_off_a: assert property (@(posedge clk) disable iff (srst)
    keyInputEnable_ff == 8'h00 |-> keyFall == 8'h00) else $error("disabled key detected");

  level_order_a: assert property (@(posedge clk) disable iff (srst)
    (ackNow_s and levelChoice_ff[pickIdx]) |-> (ready & ~levelChoice_ff) == 8'h00)
    else $error("lower level chosen over higher");

  key_rst_a: assert property (@(posedge clk)
    srst |=> keyInputEnable_ff == 8'h00) else $error("key enable not cleared by reset");

  sync_delay_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |-> ##2 keySync_ff == $past(keyLines, 2)) else $error("sync depth wrong");

  ret_then_main_a: assert property (@(posedge clk) disable iff (srst)
    instrDone && instrRet |=> !ackValid) else $error("ack straight after return");

endmodule
`default_nettype wire

// [irqh_defines.svh]
// address map, reset values and field positions of the interrupt hold block
`ifndef IRQH_DEFINES_SVH
`define IRQH_DEFINES_SVH
// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define IRQH_KEY_EN_ADDR 16'hFF6E
`define IRQH_REQ_ADDR 16'hFFE0
`define IRQH_MASK_ADDR 16'hFFE4
`define IRQH_LEVEL_ADDR 16'hFFE8
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IRQH_KEY_EN_RST 8'h00
`define IRQH_REQ_RST 8'h00
`define IRQH_MASK_RST 8'hFF
`define IRQH_LEVEL_RST 8'hFF
`define IRQH_IE_RST 1'b0
`define IRQH_ISP_RST 1'b1
// ---------------------------------------------------------------
// sources: 0..6 general inputs, 7 is the key interrupt
// ---------------------------------------------------------------
`define IRQH_NSRC 8
`define IRQH_KEY_SRC 3'h7
`endif

// [irqh_pkg.sv]
// types shared by the interrupt hold block
`default_nettype none
package irqh_pkg;
  typedef logic [7:0] irqh_byte_t;
  typedef logic [2:0] irqh_idx_t;
  typedef logic [15:0] irqh_addr_t;
endpackage
`default_nettype wire
